// ===== src/fps_seq.sv
// Purpose: Mode and start sequencer of a variable speed fire pump.
// Assumes: All inputs synchronous to I_CLK_SYS.
// Notes:   The pressure loop itself sits outside; I_SPEED_REQ is its output.
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps

module fps_seq #(
   parameter int TICK_CYC = fps_pkg::CLK_HZ / fps_pkg::TICK_HZ,
   parameter int N_SKIP   = 2
) (
   input  wire logic                  I_CLK_SYS,
   input  wire logic                  I_RST,
   input  wire fps_pkg::fps_axi_req_t I_AXI,
   output fps_pkg::fps_axi_rsp_t      O_AXI,
   input  wire logic                  I_LOCAL_START,
   input  wire logic                  I_LOCAL_STOP,
   input  wire logic                  I_PRESS_SW,
   input  wire logic                  I_DELUGE,
   input  wire logic                  I_REMOTE_START,
   input  wire logic                  I_WEEKLY_TEST,
   input  wire logic                  I_MODE_FULL,
   input  wire logic                  I_DRIVE_READY,
   input  wire logic                  I_POWER_OK,
   input  wire logic                  I_XFER_BUSY,
   input  wire logic                  I_LOCKOUT_EN,
   input  wire logic                  I_ASTOP_LOCK,
   input  wire logic [15:0]           I_PRESSURE,
   input  wire logic [15:0]           I_SPEED_REQ,
   output logic                       O_ISO_CLOSE,
   output logic                       O_DRIVE_EN,
   output logic                       O_DRIVE_FWD,
   output logic [15:0]                O_SPEED_CMD,
   output logic                       O_BP_RUN,
   output logic                       O_BP_REDUCED,
   output logic                       O_IND_DRVFAIL,
   output logic                       O_IND_BYPASS,
   output logic                       O_IND_OVERP,
   output logic                       O_IND_ASTOP,
   output logic [2:0]                 O_CONT_NO,
   output logic [2:0]                 O_CONT_NC
);
   import fps_pkg::*;

   initial begin
      if (TICK_CYC < 2 || TICK_CYC > 65535 || N_SKIP < 1 || N_SKIP > 8) begin
         $error("fps_seq: unsupported parameter values");
      end
   end

   //----------------------------------------------------------
   // Declarations
   //----------------------------------------------------------
   fps_state_t  state_r;
   logic [15:0] tick_cnt_r;
   logic        tick;
   logic [2:0]  ctrl_r;
   logic [15:0] setpt_r, rstdly_r, step_r, accel_r;
   logic [31:0] skip_r [N_SKIP];
   logic [15:0] ps_ms_r, dr_ms_r, st_ms_r;
   logic        drvfail_r, autobp_r;
   logic        aw_ok_r, w_ok_r;
   logic [AW-1:0] awaddr_r;
   logic [DW-1:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        wr_go, mstop_w, bprst_w;
   logic [DW-1:0] rd_val;
   logic        rd_hit, wr_hit;
   logic        dem_any, dem_full, astop_eff, stop_req, abort;
   logic [15:0] spd_nxt;
   logic [N_SKIP-1:0] in_up, in_dn;
   logic [23:0] p_scaled, sp_scaled;

   //----------------------------------------------------------
   // Millisecond tick
   //----------------------------------------------------------
   assign tick = (tick_cnt_r == 16'(TICK_CYC - 1));

   // Prescaler producing one pulse per millisecond.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
   end

   //----------------------------------------------------------
   // AXI4-Lite slave
   //----------------------------------------------------------
   assign wr_go   = aw_ok_r && w_ok_r && !O_AXI.bvalid;
   assign mstop_w = wr_go && awaddr_r == OFS_CMD && wstrb_r[0] && wdata_r[B_MSTOP];
   assign bprst_w = wr_go && awaddr_r == OFS_CMD && wstrb_r[0] && wdata_r[B_BPRST];

   // Merges byte lanes of a write into an old value.
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = n[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Clamps a time setting to at most ten seconds.
   function automatic logic [15:0] cap10(input logic [15:0] v);
      return (v > MAX10_MS) ? MAX10_MS : v;
   endfunction : cap10

   // Address and data are taken independently, then the write completes.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         aw_ok_r         <= 1'b0;
         w_ok_r          <= 1'b0;
         awaddr_r        <= '0;
         wdata_r         <= '0;
         wstrb_r         <= '0;
         O_AXI.awready   <= 1'b0;
         O_AXI.wready    <= 1'b0;
         O_AXI.bvalid    <= 1'b0;
         O_AXI.bresp     <= RESP_OK;
      end else begin
         O_AXI.awready <= !aw_ok_r && !(I_AXI.awvalid && O_AXI.awready);
         O_AXI.wready  <= !w_ok_r && !(I_AXI.wvalid && O_AXI.wready);
         if (I_AXI.awvalid && O_AXI.awready) begin
            aw_ok_r  <= 1'b1;
            awaddr_r <= I_AXI.awaddr;
         end
         if (I_AXI.wvalid && O_AXI.wready) begin
            w_ok_r  <= 1'b1;
            wdata_r <= I_AXI.wdata;
            wstrb_r <= I_AXI.wstrb;
         end
         if (wr_go) begin
            O_AXI.bvalid <= 1'b1;
            O_AXI.bresp  <= wr_hit ? RESP_OK : RESP_ERR;
         end else if (O_AXI.bvalid && I_AXI.bready) begin
            O_AXI.bvalid  <= 1'b0;
            aw_ok_r       <= 1'b0;
            w_ok_r        <= 1'b0;
            O_AXI.awready <= 1'b1;
            O_AXI.wready  <= 1'b1;
         end
      end
   end

   // Write address decode.
   always_comb begin
      wr_hit = awaddr_r[1:0] == 2'h0 && (awaddr_r <= OFS_STEP || awaddr_r == OFS_ACCEL);
      for (int i = 0; i < N_SKIP; i++) begin
         if (awaddr_r == OFS_SKIP0 + AW'(4 * i)) begin
            wr_hit = 1'b1;
         end
      end
   end

   // Software settings; time settings are capped on write.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         ctrl_r   <= '0;
         setpt_r  <= RV_SETPT;
         rstdly_r <= RV_RSTDLY;
         step_r   <= RV_STEP;
         accel_r  <= RV_ACCEL;
      end else if (wr_go) begin
         unique case (awaddr_r)
            OFS_CTRL:   ctrl_r   <= 3'(merge({29'h0, ctrl_r}, wdata_r, wstrb_r));
            OFS_SETPT:  setpt_r  <= 16'(merge({16'h0, setpt_r}, wdata_r, wstrb_r));
            OFS_RSTDLY: rstdly_r <= cap10(16'(merge({16'h0, rstdly_r}, wdata_r,
                                                    wstrb_r)));
            OFS_ACCEL:  accel_r  <= cap10(16'(merge({16'h0, accel_r}, wdata_r,
                                                    wstrb_r)));
            OFS_STEP: begin
               // A floor on the step keeps a full ramp inside ten seconds.
               step_r <= (16'(merge({16'h0, step_r}, wdata_r, wstrb_r)) < MIN_STEP)
                         ? MIN_STEP : 16'(merge({16'h0, step_r}, wdata_r, wstrb_r));
            end
            default: ;
         endcase
      end
   end

   // Resonant band table, one word per band: high half top, low half bottom.
   generate
      for (genvar g = 0; g < N_SKIP; g++) begin : g_skip
         always_ff @(posedge I_CLK_SYS) begin
            if (I_RST) begin
               skip_r[g] <= '0;
            end else if (wr_go && awaddr_r == OFS_SKIP0 + AW'(4 * g)) begin
               skip_r[g] <= merge(skip_r[g], wdata_r, wstrb_r);
            end
         end
         assign in_up[g] = skip_r[g][31:16] >= skip_r[g][15:0] &&
                           spd_nxt >= skip_r[g][15:0] && spd_nxt <= skip_r[g][31:16];
         assign in_dn[g] = in_up[g];
      end
   endgenerate

   // Read data mux.
   always_comb begin
      rd_hit = 1'b1;
      rd_val = '0;
      unique case (I_AXI.araddr)
         OFS_CTRL:   rd_val = {29'h0, ctrl_r};
         OFS_CMD:    rd_val = '0;
         OFS_SETPT:  rd_val = {16'h0, setpt_r};
         OFS_RSTDLY: rd_val = {16'h0, rstdly_r};
         OFS_STEP:   rd_val = {16'h0, step_r};
         OFS_ACCEL:  rd_val = {16'h0, accel_r};
         OFS_STAT:   rd_val = {21'h0, O_IND_ASTOP, O_IND_OVERP, autobp_r, drvfail_r,
                               O_BP_RUN, O_DRIVE_EN, O_ISO_CLOSE, 1'b0, state_r};
         OFS_TMR:    rd_val = {dr_ms_r, ps_ms_r};
         default: begin
            rd_hit = 1'b0;
            for (int i = 0; i < N_SKIP; i++) begin
               if (I_AXI.araddr == OFS_SKIP0 + AW'(4 * i)) begin
                  rd_hit = 1'b1;
                  rd_val = skip_r[i];
               end
            end
         end
      endcase
   end

   // Read channel answers one cycle after the address is taken.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         O_AXI.arready <= 1'b0;
         O_AXI.rvalid  <= 1'b0;
         O_AXI.rdata   <= '0;
         O_AXI.rresp   <= RESP_OK;
      end else if (I_AXI.arvalid && O_AXI.arready) begin
         O_AXI.arready <= 1'b0;
         O_AXI.rvalid  <= 1'b1;
         O_AXI.rdata   <= rd_val;
         O_AXI.rresp   <= (rd_hit && I_AXI.araddr[1:0] == 2'h0) ? RESP_OK : RESP_ERR;
      end else if (O_AXI.rvalid && I_AXI.rready) begin
         O_AXI.rvalid  <= 1'b0;
         O_AXI.arready <= 1'b1;
      end else begin
         O_AXI.arready <= !O_AXI.rvalid;
      end
   end

   //----------------------------------------------------------
   // Demand qualification
   //----------------------------------------------------------
   assign dem_full  = I_LOCAL_START || I_PRESS_SW || I_DELUGE || I_REMOTE_START;
   assign dem_any   = dem_full || (ctrl_r[B_WEEKLY] && I_WEEKLY_TEST);
   assign astop_eff = ctrl_r[B_ASTOP] && !I_ASTOP_LOCK;
   assign stop_req  = I_LOCAL_STOP || mstop_w;
   // Loss of power, transfer or lockout drops the run; demand restarts it.
   assign abort     = !I_POWER_OK || I_XFER_BUSY || !I_LOCKOUT_EN;

   //----------------------------------------------------------
   // Supervision timers
   //----------------------------------------------------------
   // Pressure switch closed time in variable speed operation.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || !I_PRESS_SW || !(state_r inside {ST_VS_DLY, ST_VS_RUN})) begin
         ps_ms_r <= '0;
      end else if (tick && ps_ms_r != PS_LIM_MS) begin
         ps_ms_r <= ps_ms_r + 16'h0001;
      end
   end

   // Demand onset to drive ready; stops counting once ready is seen.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || !dem_any || !(state_r inside {ST_VS_DLY, ST_VS_RUN})) begin
         dr_ms_r <= '0;
      end else if (tick && !I_DRIVE_READY && dr_ms_r != DR_LIM_MS) begin
         dr_ms_r <= dr_ms_r + 16'h0001;
      end
   end

   // Drive failure and automatic bypass flags hold until manual reset.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         drvfail_r <= 1'b0;
         autobp_r  <= 1'b0;
      end else begin
         if (dr_ms_r == DR_LIM_MS) begin
            drvfail_r <= 1'b1;
         end else if (bprst_w) begin
            drvfail_r <= 1'b0;
         end
         if (state_r == ST_VS_RUN && (ps_ms_r == PS_LIM_MS || dr_ms_r == DR_LIM_MS)) begin
            autobp_r <= 1'b1;
         end else if (bprst_w && state_r == ST_IDLE) begin
            autobp_r <= 1'b0;
         end
      end
   end

   //----------------------------------------------------------
   // Sequencer
   //----------------------------------------------------------
   // State timer counts milliseconds since entering the current state, or since entering ST_VS_DLY while in ST_VS_RUN or in ST_IDLE after an automatic stop.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         st_ms_r <= '0;
         state_r <= ST_IDLE;
      end else begin
         if (tick && st_ms_r != FULL_SPD) begin
            st_ms_r <= st_ms_r + 16'h0001;
         end
         if (abort || stop_req) begin
            state_r <= ST_IDLE;
            st_ms_r <= '0;
         end else begin
            unique case (state_r)
               ST_IDLE: begin
                  if (dem_full && (I_MODE_FULL || autobp_r)) begin
                     state_r <= ST_BP_OPEN;
                     st_ms_r <= '0;
                  end else if (dem_any && !I_MODE_FULL && !autobp_r) begin
                     state_r <= ST_VS_DLY;
                     st_ms_r <= '0;
                  end
               end
               ST_VS_DLY: begin
                  if (st_ms_r >= rstdly_r) begin
                     state_r <= ST_VS_RUN;
                  end
               end
               ST_VS_RUN: begin
                  if (ps_ms_r == PS_LIM_MS || dr_ms_r == DR_LIM_MS) begin
                     state_r <= ST_BP_OPEN;
                     st_ms_r <= '0;
                  end else if (astop_eff && !dem_any && O_SPEED_CMD == '0) begin
                     state_r <= ST_IDLE;
                  end
               end
               ST_BP_OPEN: begin
                  if (st_ms_r >= PAUSE_MS) begin
                     state_r <= ST_FS_RUN;
                     st_ms_r <= '0;
                  end
               end
               ST_FS_RUN: ;
            endcase
         end
      end
   end

   //----------------------------------------------------------
   // Speed ramp with resonant band skipping
   //----------------------------------------------------------
   // Automatic stop ramps to zero only after demand has gone.
   always_comb begin
      logic [15:0] tgt;
      tgt = (astop_eff && !dem_any) ? 16'h0 : I_SPEED_REQ;
      spd_nxt = O_SPEED_CMD;
      if (tgt > O_SPEED_CMD) begin
         spd_nxt = (tgt - O_SPEED_CMD > step_r) ? O_SPEED_CMD + step_r : tgt;
      end else if (tgt < O_SPEED_CMD) begin
         spd_nxt = (O_SPEED_CMD - tgt > step_r) ? O_SPEED_CMD - step_r : tgt;
      end
   end

   // Ramp steps each millisecond; a step into a band lands past it unless the band reaches full speed or zero.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || state_r != ST_VS_RUN) begin
         O_SPEED_CMD <= '0;
      end else if (tick) begin
         O_SPEED_CMD <= spd_nxt;
         for (int i = 0; i < N_SKIP; i++) begin
            if (spd_nxt > O_SPEED_CMD && in_up[i]) begin
               O_SPEED_CMD <= (skip_r[i][31:16] == FULL_SPD) ? O_SPEED_CMD
                              : skip_r[i][31:16] + 16'h0001;
            end else if (spd_nxt < O_SPEED_CMD && in_dn[i]) begin
               O_SPEED_CMD <= (skip_r[i][15:0] == 16'h0) ? 16'h0
                              : skip_r[i][15:0] - 16'h0001;
            end
         end
      end
   end

   //----------------------------------------------------------
   // Power outputs
   //----------------------------------------------------------
   // Contactors and drive only in variable speed; bypass after the pause.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         O_ISO_CLOSE  <= 1'b0;
         O_DRIVE_EN   <= 1'b0;
         O_DRIVE_FWD  <= 1'b0;
         O_BP_RUN     <= 1'b0;
         O_BP_REDUCED <= 1'b0;
      end else begin
         O_ISO_CLOSE  <= state_r inside {ST_VS_DLY, ST_VS_RUN};
         O_DRIVE_EN   <= state_r inside {ST_VS_DLY, ST_VS_RUN};
         O_DRIVE_FWD  <= state_r == ST_VS_RUN;
         O_BP_RUN     <= state_r == ST_FS_RUN;
         O_BP_REDUCED <= state_r == ST_FS_RUN && ctrl_r[B_REDUCED] &&
                         st_ms_r < accel_r;
      end
   end

   //----------------------------------------------------------
   // Indicators and changeover contacts
   //----------------------------------------------------------
   assign p_scaled  = 24'(I_PRESSURE) * 24'(OVP_DEN);
   assign sp_scaled = 24'(setpt_r) * 24'(OVP_NUM);

   // Lamps, and complementary contact pairs for the drive failure, bypass and overpressure lamps.
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         O_IND_DRVFAIL <= 1'b0;
         O_IND_BYPASS  <= 1'b0;
         O_IND_OVERP   <= 1'b0;
         O_IND_ASTOP   <= 1'b0;
         O_CONT_NO     <= 3'h0;
         O_CONT_NC     <= 3'h7;
      end else begin
         O_IND_DRVFAIL <= drvfail_r;
         O_IND_BYPASS  <= autobp_r;
         O_IND_OVERP   <= p_scaled > sp_scaled;
         O_IND_ASTOP   <= astop_eff;
         O_CONT_NO     <= {p_scaled > sp_scaled, autobp_r, drvfail_r};
         O_CONT_NC     <= ~{p_scaled > sp_scaled, autobp_r, drvfail_r};
      end
   end

endmodule : fps_seq

// ===== shared/fps_pkg.sv
// Purpose: Constants and carriers for the fire pump mode sequencer.
// Assumes: 50 MHz system clock, AXI4-Lite register access.
// Notes:   Times are in milliseconds of the internal tick.
package fps_pkg;

   //----------------------------------------------------------
   // Bus layout
   //----------------------------------------------------------
   localparam int AW = 8;
   localparam int DW = 32;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   //----------------------------------------------------------
   // Register byte offsets
   //----------------------------------------------------------
   localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
   localparam logic [AW-1:0] OFS_CMD    = 8'h04;
   localparam logic [AW-1:0] OFS_SETPT  = 8'h08;
   localparam logic [AW-1:0] OFS_RSTDLY = 8'h0C;
   localparam logic [AW-1:0] OFS_STEP   = 8'h10;
   localparam logic [AW-1:0] OFS_ACCEL  = 8'h14;
   localparam logic [AW-1:0] OFS_STAT   = 8'h18;
   localparam logic [AW-1:0] OFS_TMR    = 8'h1C;
   localparam logic [AW-1:0] OFS_SKIP0  = 8'h20;

   //----------------------------------------------------------
   // Field positions
   //----------------------------------------------------------
   localparam int B_ASTOP   = 0;
   localparam int B_REDUCED = 1;
   localparam int B_WEEKLY  = 2;
   localparam int B_MSTOP   = 0;
   localparam int B_BPRST   = 1;

   //----------------------------------------------------------
   // Timing and limits
   //----------------------------------------------------------
   localparam int          CLK_HZ     = 50_000_000;
   localparam int          TICK_HZ    = 1000;
   localparam logic [15:0] PS_LIM_MS  = 16'd15000;
   localparam logic [15:0] DR_LIM_MS  = 16'd5000;
   localparam logic [15:0] MAX10_MS   = 16'd10000;
   localparam logic [15:0] PAUSE_MS   = 16'd3000;
   localparam logic [15:0] FULL_SPD   = 16'hFFFF;
   localparam logic [15:0] MIN_STEP   = 16'h0007;
   localparam logic [7:0]  OVP_NUM    = 8'd115;
   localparam logic [7:0]  OVP_DEN    = 8'd100;

   //----------------------------------------------------------
   // Reset values
   //----------------------------------------------------------
   localparam logic [15:0] RV_SETPT  = 16'h1000;
   localparam logic [15:0] RV_RSTDLY = 16'h03E8;
   localparam logic [15:0] RV_STEP   = 16'h0040;
   localparam logic [15:0] RV_ACCEL  = 16'h1388;

   typedef enum logic [2:0] {
      ST_IDLE, ST_VS_DLY, ST_VS_RUN, ST_BP_OPEN, ST_FS_RUN
   } fps_state_t;

   typedef struct packed {
      logic          awvalid;
      logic [AW-1:0] awaddr;
      logic          wvalid;
      logic [DW-1:0] wdata;
      logic [3:0]    wstrb;
      logic          bready;
      logic          arvalid;
      logic [AW-1:0] araddr;
      logic          rready;
   } fps_axi_req_t;

   typedef struct packed {
      logic          awready;
      logic          wready;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          arready;
      logic          rvalid;
      logic [DW-1:0] rdata;
      logic [1:0]    rresp;
   } fps_axi_rsp_t;

endpackage : fps_pkg

// ===== dv/fps_seq_asserts.sv
// Purpose: Port assertions of the pump sequencer.
// Assumes: Bound into every fps_seq.
// Notes:   Stop causes are remembered for four cycles.
`timescale 1ns/1ps
module fps_seq_chk (
   input wire logic                  I_CLK_SYS,
   input wire logic                  I_RST,
   input wire fps_pkg::fps_axi_req_t I_AXI,
   input wire logic                  I_LOCAL_STOP,
   input wire logic                  I_POWER_OK,
   input wire logic                  I_XFER_BUSY,
   input wire logic                  I_LOCKOUT_EN,
   input wire logic                  O_ISO_CLOSE,
   input wire logic                  O_DRIVE_EN,
   input wire logic                  O_DRIVE_FWD,
   input wire logic                  O_BP_RUN,
   input wire logic                  O_BP_REDUCED,
   input wire logic                  O_IND_DRVFAIL,
   input wire logic                  O_IND_BYPASS,
   input wire logic                  O_IND_OVERP,
   input wire logic [2:0]            O_CONT_NO,
   input wire logic [2:0]            O_CONT_NC
);
   import fps_pkg::*;
   logic [3:0] stop_r;
   // History of any manual or supply stop cause, a bus write included.
   always_ff @(posedge I_CLK_SYS) begin
      stop_r <= {stop_r[2:0], I_LOCAL_STOP | ~I_POWER_OK | I_XFER_BUSY | ~I_LOCKOUT_EN
                 | I_AXI.awvalid};
   end
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);
   // -----------------------------------------------------------
   // Contacts, contactors and bypass
   // -----------------------------------------------------------
   a_cont_pair: assert property (O_CONT_NC == ~O_CONT_NO)
      else $error("Contact pair not complementary.");
   a_cont_lamp: assert property (O_CONT_NO == {O_IND_OVERP, O_IND_BYPASS, O_IND_DRVFAIL})
      else $error("Contact differs from lamp.");
   a_bp_iso: assert property (!(O_BP_RUN && O_ISO_CLOSE))
      else $error("Bypass and contactors both on.");
   a_fwd_path: assert property (O_DRIVE_FWD |-> O_DRIVE_EN && O_ISO_CLOSE)
      else $error("Forward run without drive path.");
   a_iso_drive: assert property (O_ISO_CLOSE == O_DRIVE_EN)
      else $error("Contactors and drive disagree.");
   a_byp_latch: assert property ($fell(O_IND_BYPASS) |-> !O_BP_RUN && !O_ISO_CLOSE)
      else $error("Bypass lamp cleared while running.");
   a_fs_hold: assert property ($fell(O_BP_RUN) |-> stop_r != 4'h0)
      else $error("Full speed run stopped by itself.");
   a_reduced: assert property (O_BP_REDUCED |-> O_BP_RUN)
      else $error("Reduced start outside bypass run.");
   c_bp: cover property ($rose(O_BP_RUN));
   c_fail: cover property ($rose(O_IND_DRVFAIL));
   c_ovp: cover property ($rose(O_IND_OVERP));
endmodule : fps_seq_chk
bind fps_seq fps_seq_chk u_chk (.*);

// ===== dv/fps_drv_mdl.sv
// Purpose: Motor drive model giving ready after a boot delay.
// Assumes: Ready drops as soon as the drive is not energised.
// Notes:   i_dead models a failed drive that never gets ready.
`timescale 1ns/1ps
module fps_drv_mdl #(
   parameter int DLY = 5
) (
   input  wire logic i_clk,
   input  wire logic i_en,
   input  wire logic i_dead,
   output logic      o_ready
);
   logic [7:0] cnt_r;
   // Boot count runs while energised, far inside the readiness time.
   always_ff @(posedge i_clk) begin
      if (!i_en || i_dead) cnt_r <= 8'h00;
      else if (cnt_r != 8'(DLY)) cnt_r <= cnt_r + 8'h01;
   end
   assign o_ready = i_en && !i_dead && cnt_r == 8'(DLY);
endmodule : fps_drv_mdl

// ===== dv/tb_top.sv
// Purpose: Self-checking bench of the pump sequencer.
// Assumes: TICK_CYC of 4, so one millisecond is four cycles.
// Notes:   Random set point and speed request, fixed seed.
`timescale 1ns/1ps
module tb_top;
   import fps_pkg::*;
   logic clk = 1'b0, rst = 1'b1, stp = 1'b0, full = 1'b0, pok = 1'b1, dead = 1'b0;
   logic xfr = 1'b0, lk = 1'b1, ast;
   logic rdy, iso, den, fwd, bpr, bpred, fail, byp, ovp;
   logic [3:0] dem = 4'h0;
   logic [15:0] prs = 16'h0, sreq = 16'h0, spd;
   logic [2:0] cno, cnc;
   logic [1:0] rr;
   logic [31:0] d, sp;
   fps_axi_req_t ax = '0;
   fps_axi_rsp_t rs;
   int err_total = 0, n_compared = 0, cyc = 0, n;
   always #10 clk = ~clk;
   fps_drv_mdl #(.DLY(5)) u_drv (.i_clk(clk), .i_en(den), .i_dead(dead), .o_ready(rdy));
   fps_seq #(.TICK_CYC(4)) DUT (.I_CLK_SYS(clk), .I_RST(rst), .I_AXI(ax), .O_AXI(rs),
      .I_LOCAL_START(dem[0]), .I_LOCAL_STOP(stp), .I_PRESS_SW(dem[1]), .I_DELUGE(dem[2]),
      .I_REMOTE_START(dem[3]), .I_WEEKLY_TEST(1'b0), .I_MODE_FULL(full), .I_DRIVE_READY(rdy),
      .I_POWER_OK(pok), .I_XFER_BUSY(xfr), .I_LOCKOUT_EN(1'b1), .I_ASTOP_LOCK(lk),
      .I_PRESSURE(prs), .I_SPEED_REQ(sreq), .O_ISO_CLOSE(iso), .O_DRIVE_EN(den),
      .O_DRIVE_FWD(fwd), .O_SPEED_CMD(spd), .O_BP_RUN(bpr), .O_BP_REDUCED(bpred),
      .O_IND_DRVFAIL(fail), .O_IND_BYPASS(byp), .O_IND_OVERP(ovp), .O_IND_ASTOP(ast),
      .O_CONT_NO(cno), .O_CONT_NC(cnc));
   task automatic final_report;
      if (err_total == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] e, input logic [31:0] a);
      n_compared++;
      if (a !== e) begin
         err_total++;
         $display("MISMATCH t=%0t exp=%h act=%h", $time, e, a);
      end
   endtask : chk
   task automatic wt(ref logic s, input int lim);
      n = 0;
      while (s !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask : wt
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      ax <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:v, wstrb:4'hF, bready:1'b1, default:'0};
      do begin
         @(posedge clk);
         if (rs.awready) ax.awvalid <= 1'b0;
         if (rs.wready) ax.wvalid <= 1'b0;
      end while (rs.bvalid !== 1'b1);
      rr = rs.bresp;
      ax.bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      ax <= '{arvalid:1'b1, araddr:a, rready:1'b1, default:'0};
      do begin
         @(posedge clk);
         if (rs.arready) ax.arvalid <= 1'b0;
      end while (rs.rvalid !== 1'b1);
      d = rs.rdata;
      rr = rs.rresp;
      ax.rready <= 1'b0;
   endtask : axr
   // Hang guard: a run past the ceiling counts as a mismatch.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 70000) begin
         err_total++;
         final_report;
      end
   end
   // Main sequence: registers, overpressure, starts, drive failure, full mode.
   initial begin
      void'($urandom(32'hAE93));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      chk(32'h7, cnc);
      sp = 32'h100 + ($urandom % 32'h3F00);
      axw(OFS_SETPT, sp);
      axw(OFS_RSTDLY, 32'h2);
      axr(8'h40);
      chk(RESP_ERR, rr);
      axr(OFS_SETPT);
      chk(sp, d);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         prs <= 16'((sp * 32'h73) / 32'h64 + i);
         repeat (4) @(posedge clk);
         chk(32'(i), ovp);
         chk(32'(i), cno[2]);
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         prs <= 16'h0;
         sreq <= 16'($urandom);
         dem <= 4'h1 << i;
         wt(iso, 10);
         chk(32'h1, den);
         wt(fwd, 40);
         chk(32'h1, fwd);
         dem <= 4'h0;
         repeat (20) @(posedge clk);
         chk(32'h1, fwd);
         chk(32'h1, spd != 16'h0 || sreq == 16'h0);
         if (i == 3) xfr <= 1'b1;
         else if (i == 2) axw(OFS_CMD, 32'h1);
         else if (i == 1) pok <= 1'b0;
         else stp <= 1'b1;
         repeat (4) @(posedge clk);
         chk(32'h0, iso);
         chk(32'h0, spd);
         pok <= 1'b1;
         stp <= 1'b0;
         xfr <= 1'b0;
      end
      axw(OFS_CTRL, 32'h3);
      repeat (2) @(posedge clk);
      chk(32'h0, ast);
      lk <= 1'b0;
      repeat (2) @(posedge clk);
      chk(32'h1, ast);
      lk <= 1'b1;
      @(posedge clk);
      dead <= 1'b1;
      dem <= 4'h1;
      wt(fail, 21000);
      chk(32'h1, n >= 19990 && n <= 20020);
      chk(32'h1, cno[0]);
      wt(bpr, 17000);
      chk(32'h1, n >= 8000 && n <= 16000);
      chk(32'h1, bpred);
      chk(32'h1, byp);
      dem <= 4'h0;
      repeat (50) @(posedge clk);
      chk(32'h1, bpr);
      stp <= 1'b1;
      repeat (4) @(posedge clk);
      stp <= 1'b0;
      chk(32'h1, byp);
      axw(OFS_CMD, 32'h2);
      repeat (4) @(posedge clk);
      chk(32'h0, byp);
      dead <= 1'b0;
      full <= 1'b1;
      dem <= 4'h8;
      wt(bpr, 17000);
      chk(32'h1, bpr);
      chk(32'h0, byp);
      final_report;
   end
endmodule : tb_top
